//--- rtl/sep_port.sv
/*
  Serial EEPROM command port: pin sampling, instruction decode, read
  prefetch FIFO, page buffer, self-timed write/erase engine, deep sleep.
  Assumes a host drives cs_n, sck, si, hold_n slower than ref_clk / 8.
*/
// Operation
// - First byte fills an eight-bit instruction register before address or data.
// - Serial input is captured on each rising serial clock while selected and active.
// - All bytes travel most significant bit first, both directions.
// - First instruction bit is taken on first rising clock after select falls.
// - Pause freezes the transfer; release resumes at the same point.
// - Code 03 reads, code 02 writes, both from the supplied address.
// - Code 06 sets the write-enable latch, code 04 clears it.
// - Large parts decode 42 page erase, D8 sector erase, C7 whole erase.
// - Large parts decode AB wake with signature and B9 deep sleep.
// - Whole-array erase ends and reports not busy within 15 ms.
// - Write cycle ends within 6 ms on large parts, 5 ms on small.
// - Deep sleep is reached within 100 us after select rises.
// - Read pointer advances per byte, wraps to zero, stops at select rise.
// - Latch set only at select rise after exactly eight instruction bits.
// - Write commits only if select rises right after a data byte's last bit.
`include "sep_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module sep_fifo
  import sep_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp, rp, next_wp, next_rp;
  logic [AW:0]      cnt, next_cnt;
  logic             push, pop;

  // Pointer and count update
  always_comb
  begin
    in_ready  = (cnt != DEPTH[AW:0]);
    out_valid = (cnt != '0);
    out_data  = mem[rp];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    next_wp   = push ? AW'(wp + 1'b1) : wp;
    next_rp   = pop ? AW'(rp + 1'b1) : rp;
    next_cnt  = AW'(1) == AW'(1) ? (cnt + {AW'(0), push} - {AW'(0), pop}) : cnt;
    if (flush)
    begin
      next_wp  = '0;
      next_rp  = '0;
      next_cnt = '0;
    end
  end

  // Registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end
    else
    begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
  end

  // Storage
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wp] <= in_data;
  end
endmodule : sep_fifo

module sep_port
  import sep_pkg::*;
#(
  parameter bit     LARGE  = 1'b1,
  parameter logic [7:0] SIG = 8'h5A, // Arbitrary signature value
  parameter int     WC_CYC = (LARGE ? `SEP_TWC_LG_MS : `SEP_TWC_SM_MS) * `SEP_CLK_KHZ,
  parameter int     SE_CYC = `SEP_TSE_MS * `SEP_CLK_KHZ,
  parameter int     CE_CYC = `SEP_TCE_MS * `SEP_CLK_KHZ
)(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Serial pins
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic hold_n,
  output logic      so_out,
  output logic      so_oe,
  // Status
  output logic      busy,
  output logic      deep_sleep
);
  localparam logic [11:0] TPD_CYC = 12'(`SEP_TPD_CYC);
  sep_pin_t    p1, p2;
  logic        sck_d, cs_d, sel, act, rise, fall, cs_rise;
  logic [7:0]  mem [`SEP_ARRAY_N];
  logic [7:0]  pbuf [`SEP_PAGE_N];
  logic [255:0] pvalid;
  // Link state
  sep_st_t     state, next_state;
  logic [7:0]  op, next_op, sh, next_sh, out_sh, next_out_sh, swb, next_swb;
  logic [2:0]  bitcnt, next_bitcnt, obit, next_obit;
  logic        nbytes, next_nbytes, extra, next_extra, have, next_have;
  logic [15:0] addr, next_addr, pf_ptr, next_pf_ptr;
  logic [7:0]  wofs, next_wofs;
  logic        so_q, next_so_q, oe_q, next_oe_q, pf_on, next_pf_on;
  logic [7:0]  byte_in, f_data;
  logic        done, f_valid, f_ready, pop, pb_we, pv_clr;
  sep_evt_t    ev;
  // Engine state
  sep_eop_t    eop, next_eop;
  logic        next_busy, wel, next_wel, wpen, next_wpen, next_dsl;
  logic [1:0]  bp, next_bp;
  logic [16:0] idx, next_idx, span;
  logic [19:0] tmr, next_tmr;
  logic [15:0] ebase, next_ebase, mem_a;
  logic [11:0] dcnt, next_dcnt;
  logic        dpend, next_dpend, mem_we;
  logic [7:0]  status;

  // Two-stage pin synchronisers, then edge history
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p1    <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1};
      p2    <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1};
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end
    else
    begin
      p1    <= '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n};
      p2    <= p1;
      sck_d <= p2.sck;
      cs_d  <= p2.cs_n;
    end
  end

  // Edge qualification: paused clock edges never reach the link
  assign sel     = !p2.cs_n;
  assign act     = sel & p2.hold_n;
  assign rise    = act & p2.sck & !sck_d;
  assign fall    = act & !p2.sck & sck_d;
  assign cs_rise = p2.cs_n & !cs_d;
  assign byte_in = {sh[6:0], p2.si};
  assign done    = rise & (bitcnt == `SEP_BIT_LAST);
  assign status  = {wpen, 3'h0, bp, wel, busy};
  assign pop     = fall & (state == S_DATA_OUT) & (obit == 3'h0) & (op == `SEP_OP_READ);

  // Read prefetch buffer; the shifter stalls it until a byte is due
  sep_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .flush     (!sel),
    .in_valid  (pf_on),
    .in_ready  (f_ready),
    .in_data   (mem[pf_ptr]),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data)
  );

  // Link next values: shift, decode, output shift, commit events
  always_comb
  begin
    next_state = state; next_op = op; next_sh = sh; next_bitcnt = bitcnt;
    next_nbytes = nbytes; next_extra = extra; next_have = have;
    next_addr = addr; next_wofs = wofs; next_swb = swb; next_out_sh = out_sh;
    next_obit = obit; next_so_q = so_q; next_oe_q = oe_q;
    next_pf_on = pf_on; next_pf_ptr = pf_ptr;
    pb_we = 1'b0; pv_clr = 1'b0; ev = '0;
    if (pf_on && f_ready)
      next_pf_ptr = pf_ptr + 16'h1;
    // Commit at select rise, only on a clean byte boundary
    if (cs_rise && bitcnt == 3'h0)
    begin
      ev.wel_set = (state == S_IGNORE) && !extra && op == `SEP_OP_SET;
      ev.wel_clr = (state == S_IGNORE) && !extra && op == `SEP_OP_CLEAR;
      ev.sleep   = (state == S_IGNORE) && !extra && op == `SEP_OP_SLEEP;
      ev.ce      = (state == S_IGNORE) && !extra && op == `SEP_OP_CE && wel && !busy;
      ev.pe      = (state == S_IGNORE) && !extra && op == `SEP_OP_PE && wel && !busy;
      ev.se      = (state == S_IGNORE) && !extra && op == `SEP_OP_SE && wel && !busy;
      ev.sr      = (state == S_IGNORE) && !extra && op == `SEP_OP_SWR && wel && !busy;
      ev.wr      = (state == S_DATA_IN) && have && wel && !busy;
    end
    if (!sel)
    begin
      // Deselected: restart at the instruction byte, stop reading
      next_state = S_CMD; next_bitcnt = 3'h0; next_oe_q = 1'b0;
      next_pf_on = 1'b0; next_extra = 1'b0;
    end
    else if (rise)
    begin
      next_sh     = byte_in;
      next_bitcnt = bitcnt + 3'h1;
      if (state == S_IGNORE || state == S_DATA_OUT || state == S_STAT_OUT)
        next_extra = 1'b1;
      if (done)
        case (state)
          S_CMD:
          begin
            next_op     = byte_in;
            next_nbytes = 1'b0;
            next_obit   = 3'h0;
            next_state  = S_IGNORE;
            if (deep_sleep)
            begin
              if (LARGE && byte_in == `SEP_OP_WAKE)
              begin
                next_state = S_ADDR;
                ev.wake    = 1'b1;
              end
              else
                next_op = 8'h00;                    // Asleep: other codes do nothing
            end
            else if (byte_in == `SEP_OP_READ || byte_in == `SEP_OP_WRITE)
              next_state = busy ? S_IGNORE : S_ADDR;
            else if (LARGE && (byte_in == `SEP_OP_PE || byte_in == `SEP_OP_SE))
              next_state = S_ADDR;
            else if (LARGE && byte_in == `SEP_OP_WAKE)
              next_state = S_ADDR;
            else if (byte_in == `SEP_OP_SRD)
            begin
              next_state = S_STAT_OUT;
              next_oe_q  = 1'b1;
            end
            else if (byte_in == `SEP_OP_SWR)
              next_state = S_STAT_IN;
            else if (!LARGE && (byte_in == `SEP_OP_CE || byte_in == `SEP_OP_SLEEP ||
                                byte_in == `SEP_OP_PE || byte_in == `SEP_OP_SE))
              next_op = 8'h00;                      // Unknown on small parts
          end
          S_ADDR:
          begin
            next_addr   = {addr[7:0], byte_in};
            next_nbytes = 1'b1;
            if (nbytes)
              case (op)
                `SEP_OP_READ:
                begin
                  next_state  = S_DATA_OUT;
                  next_oe_q   = 1'b1;
                  next_pf_on  = 1'b1;
                  next_pf_ptr = {addr[7:0], byte_in};
                end
                `SEP_OP_WAKE:
                begin
                  next_state = S_DATA_OUT;
                  next_oe_q  = 1'b1;
                end
                `SEP_OP_WRITE:
                begin
                  next_state = S_DATA_IN;
                  next_have  = 1'b0;
                  next_wofs  = byte_in;
                  pv_clr     = 1'b1;
                end
                default:
                  next_state = S_IGNORE;
              endcase
          end
          S_DATA_IN:
          begin
            pb_we     = 1'b1;                       // Wraps inside the page
            next_wofs = wofs + 8'h1;
            next_have = 1'b1;
          end
          S_STAT_IN:
          begin
            next_swb   = byte_in;
            next_state = S_IGNORE;
            next_extra = 1'b0;
          end
          default:
            next_state = state;
        endcase
    end
    else if (fall && (state == S_DATA_OUT || state == S_STAT_OUT))
    begin
      next_obit = obit + 3'h1;
      if (obit == 3'h0)
      begin
        if (state == S_STAT_OUT)
          {next_so_q, next_out_sh} = {status, 1'b0};
        else if (op == `SEP_OP_WAKE)
          {next_so_q, next_out_sh} = {SIG, 1'b0};
        else
          {next_so_q, next_out_sh} = {f_valid ? f_data : `SEP_ERASED, 1'b0};
      end
      else
        {next_so_q, next_out_sh} = {out_sh, 1'b0};
    end
  end

  // Link registers; a pause leaves all but pf_ptr untouched, as prefetch can still advance it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= S_CMD; op <= 8'h00; sh <= 8'h00; bitcnt <= 3'h0;
      nbytes <= 1'b0; extra <= 1'b0; have <= 1'b0; addr <= 16'h0000;
      wofs <= 8'h00; swb <= 8'h00; out_sh <= 8'h00; obit <= 3'h0;
      so_q <= 1'b0; oe_q <= 1'b0; pf_on <= 1'b0; pf_ptr <= 16'h0000;
    end
    else
    begin
      state <= next_state; op <= next_op; sh <= next_sh; bitcnt <= next_bitcnt;
      nbytes <= next_nbytes; extra <= next_extra; have <= next_have;
      addr <= next_addr; wofs <= next_wofs; swb <= next_swb;
      out_sh <= next_out_sh; obit <= next_obit; so_q <= next_so_q;
      oe_q <= next_oe_q; pf_on <= next_pf_on; pf_ptr <= next_pf_ptr;
    end
  end

  // Output pin: floats when paused or deselected
  assign so_out = so_q;
  assign so_oe  = oe_q & act;

  // Engine next values: self-timed cycles, latch, status, deep sleep
  always_comb
  begin
    next_busy = busy; next_eop = eop; next_idx = idx; next_tmr = tmr;
    next_ebase = ebase; next_wel = wel; next_bp = bp; next_wpen = wpen;
    next_dsl = deep_sleep; next_dcnt = dcnt; next_dpend = dpend;
    mem_we = 1'b0; mem_a = 16'h0000;
    case (eop)
      E_SE:    span = `SEP_SECT_N;
      E_CE:    span = `SEP_ARRAY_N;
      E_SR:    span = 17'h0;
      default: span = `SEP_PAGE_N;
    endcase
    if (busy)
    begin
      if (idx < span)
      begin
        next_idx = idx + 17'h1;
        case (eop)
          E_WRITE:
          begin
            mem_a  = {ebase[15:8], idx[7:0]};
            mem_we = pvalid[idx[7:0]];
          end
          E_PE:
          begin
            mem_a  = {ebase[15:8], idx[7:0]};
            mem_we = 1'b1;
          end
          E_SE:
          begin
            mem_a  = {ebase[15:14], idx[13:0]};
            mem_we = 1'b1;
          end
          E_CE:
          begin
            mem_a  = idx[15:0];
            mem_we = 1'b1;
          end
          default:
            mem_we = 1'b0;
        endcase
      end
      if (tmr == 20'h0)
      begin
        next_busy = 1'b0;
        next_wel  = 1'b0;
        next_eop  = E_IDLE;
      end
      else
        next_tmr = tmr - 20'h1;
    end
    else if (ev.wr || ev.pe || ev.se || ev.ce || ev.sr)
    begin
      next_busy  = 1'b1;
      next_idx   = 17'h0;
      next_ebase = addr;
      next_eop   = ev.wr ? E_WRITE : ev.pe ? E_PE : ev.se ? E_SE : ev.ce ? E_CE : E_SR;
      next_tmr   = ev.ce ? 20'(CE_CYC - 1) : ev.se ? 20'(SE_CYC - 1) : 20'(WC_CYC - 1);
      if (ev.sr)
      begin
        next_bp   = {swb[`SEP_SB_BP1], swb[`SEP_SB_BP0]};
        next_wpen = swb[`SEP_SB_WPEN];
      end
    end
    if (ev.wel_set)
      next_wel = 1'b1;
    if (ev.wel_clr)
      next_wel = 1'b0;
    if (ev.sleep)
    begin
      next_dpend = 1'b1;
      next_dcnt  = TPD_CYC - `SEP_SYNC_LAG;        // Pin sync and commit delay come off the budget
    end
    else if (dpend)
    begin
      if (dcnt == 12'h0)
      begin
        next_dsl   = 1'b1;
        next_dpend = 1'b0;
      end
      else
        next_dcnt = dcnt - 12'h1;
    end
    if (ev.wake)
    begin
      next_dsl   = 1'b0;
      next_dpend = 1'b0;
    end
  end

  // Engine registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0; eop <= E_IDLE; idx <= 17'h0; tmr <= 20'h0;
      ebase <= 16'h0000; wel <= 1'b0; bp <= 2'h0; wpen <= 1'b0;
      deep_sleep <= 1'b0; dcnt <= 12'h0; dpend <= 1'b0;
    end
    else
    begin
      busy <= next_busy; eop <= next_eop; idx <= next_idx; tmr <= next_tmr;
      ebase <= next_ebase; wel <= next_wel; bp <= next_bp; wpen <= next_wpen;
      deep_sleep <= next_dsl; dcnt <= next_dcnt; dpend <= next_dpend;
    end
  end

  // Array, page buffer and its byte-valid flags
  always_ff @(posedge ref_clk)
  begin
    if (mem_we)
      mem[mem_a] <= (eop == E_WRITE) ? pbuf[idx[7:0]] : `SEP_ERASED;
    if (pb_we)
      pbuf[wofs] <= byte_in;
    if (pv_clr)
      pvalid <= '0;
    else if (pb_we)
      pvalid[wofs] <= 1'b1;
  end

  // Checks
  a_cmd_eight: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == S_CMD && sel && !done) |=> state == S_CMD)
    else $error("instruction left before eight bits");
  a_rise_sample: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rise |=> sh[0] == $past(p2.si))
    else $error("serial input not captured on rise");
  a_msb_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fall && state == S_DATA_OUT && obit != 3'h0) |=> so_q == $past(out_sh[7]))
    else $error("output not msb first");
  a_first_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(sel) |-> (state == S_CMD && bitcnt == 3'h0))
    else $error("instruction not restarted at select");
  a_hold_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sel && !p2.hold_n) ##1 sel |-> $stable(bitcnt) && $stable(sh) && $stable(state))
    else $error("transfer moved while paused");
  a_read_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state == S_CMD && done && byte_in == `SEP_OP_READ && !busy && !deep_sleep)
    |=> state == S_ADDR && op == `SEP_OP_READ)
    else $error("read code not decoded");
  a_wel_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ev.wel_set |=> wel ##0 $past(op) == `SEP_OP_SET)
    else $error("latch set failed");
  a_cycle_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (busy && eop != E_CE && eop != E_SE) |-> tmr < 20'(WC_CYC))
    else $error("write cycle exceeds its time");
  a_erase_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (busy && tmr == 20'h0 && !ev.wel_set) |=> !busy && !wel)
    else $error("busy not released at timer end");
  a_sleep_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (dpend && dcnt == 12'h0) |=> deep_sleep)
    else $error("deep sleep not reached");
  a_ptr_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sel && pf_on && f_ready && pf_ptr == '1) |=> pf_ptr == 16'h0000)
    else $error("read pointer did not wrap");
  a_abandon_wr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cs_rise && state == S_DATA_IN && bitcnt != 3'h0) |-> !ev.wr)
    else $error("partial byte committed");
  a_hold_float: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !p2.hold_n |-> !so_oe)
    else $error("output driven while paused");
endmodule : sep_port

`default_nettype wire

//--- rtl/sep_cfg.svh
/*
  Constants of the serial EEPROM command port: instruction codes, status
  bit positions, array geometry and timing figures.
  Assumes inclusion by rtl files that run on the 40 MHz reference clock.
*/
`ifndef SEP_CFG_SVH
`define SEP_CFG_SVH

// Instruction codes
`define SEP_OP_READ   8'h03
`define SEP_OP_WRITE  8'h02
`define SEP_OP_SET    8'h06
`define SEP_OP_CLEAR  8'h04
`define SEP_OP_SRD    8'h05
`define SEP_OP_SWR    8'h01
`define SEP_OP_PE     8'h42
`define SEP_OP_SE     8'hD8
`define SEP_OP_CE     8'hC7
`define SEP_OP_WAKE   8'hAB
`define SEP_OP_SLEEP  8'hB9

// Status bit positions
`define SEP_SB_WIP    0
`define SEP_SB_WEL    1
`define SEP_SB_BP0    2
`define SEP_SB_BP1    3
`define SEP_SB_WPEN   7

// Array geometry
`define SEP_PAGE_N    17'h00100
`define SEP_SECT_N    17'h04000
`define SEP_ARRAY_N   17'h10000
`define SEP_ERASED    8'hFF
`define SEP_BIT_LAST  3'h7

// Timing figures
`define SEP_CLK_KHZ   40000
`define SEP_TWC_LG_MS 6
`define SEP_TWC_SM_MS 5
`define SEP_TCE_MS    15
`define SEP_TSE_MS    15
`define SEP_TPD_US    100
`define SEP_TPD_CYC   ((`SEP_TPD_US * `SEP_CLK_KHZ) / 1000)
`define SEP_SYNC_LAG  12'h004

`endif

//--- rtl/sep_pkg.sv
/*
  Types of the serial EEPROM command port.
  Assumes sep_cfg.svh supplies the numeric constants.
*/
`default_nettype none
package sep_pkg;
  // Link phases
  typedef enum {S_CMD, S_ADDR, S_DATA_IN, S_DATA_OUT, S_STAT_OUT, S_STAT_IN,
                S_IGNORE} sep_st_t;
  // Self-timed operations
  typedef enum {E_IDLE, E_WRITE, E_PE, E_SE, E_CE, E_SR} sep_eop_t;
  // Events passed from the link side to the engine
  typedef struct packed {
    logic wr;
    logic pe;
    logic se;
    logic ce;
    logic sr;
    logic wel_set;
    logic wel_clr;
    logic sleep;
    logic wake;
  } sep_evt_t;
  // Synchronised pin levels
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
  } sep_pin_t;
endpackage : sep_pkg
`default_nettype wire

//--- bench/sep_host.sv
/*
  Host model for the EEPROM command port: drives select, serial clock,
  serial input and pause, and collects bytes from the serial output.
  Assumes ref_clk is the bench clock; tb calls frame() hierarchically.
*/
`timescale 1ns/100ps
`default_nettype none
module sep_host (
  // Clock
  input  wire logic       ref_clk,
  // Serial pins
  output logic            cs_n,
  output logic            sck,
  output logic            si,
  output logic            hold_n,
  input  wire logic       so_out,
  input  wire logic       so_oe,
  // Collected data
  output logic [7:0]      rx_byte,
  output logic            rx_stb,
  output logic            leak
);
  logic r;
  // Idle pins
  initial
  begin
    {cs_n, sck, si, hold_n, rx_stb, leak, r, rx_byte} = {4'hB, 3'h0, 8'h00};
  end
  // One bit: low half, rise, high half, sample, fall
  task automatic bit_x(input logic b);
    si = b;
    repeat (4) @(negedge ref_clk);
    sck = 1'b1;
    repeat (4) @(negedge ref_clk);
    r = so_oe ? so_out : ~r; // Released line shows the inverse
    sck = 1'b0;
  endtask : bit_x
  // Pause with junk clocks that must be ignored
  task automatic pause();
    hold_n = 1'b0;
    repeat (2)
    begin
      repeat (4) @(negedge ref_clk);
      sck = 1'b1;
      si = ~si;
      repeat (4) @(negedge ref_clk);
      leak = leak | so_oe;
      sck = 1'b0;
    end
    repeat (4) @(negedge ref_clk);
    hold_n = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask : pause
  // Whole frame: bytes out, bytes in, optional pause and stray bits
  task automatic frame(input logic [7:0] tx[$], input int nrx, input int hold_at,
                       input int extra);
    logic [7:0] v;
    cs_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    foreach (tx[i])
      for (int k = 7; k >= 0; k--) bit_x(tx[i][k]);
    for (int n = 0; n < nrx; n++)
    begin
      if (n == hold_at) pause();
      for (int k = 7; k >= 0; k--)
      begin
        bit_x(1'b0);
        v[k] = r;
      end
      rx_byte = v;
      rx_stb = 1'b1;
      @(negedge ref_clk);
      rx_stb = 1'b0;
    end
    repeat (extra) bit_x(1'b1);
    cs_n = 1'b1;
    si = ~si;
    repeat (8) @(negedge ref_clk);
  endtask : frame
endmodule : sep_host
`default_nettype wire

//--- bench/tb.sv
/*
  Self-checking bench for the EEPROM command port, prefetch FIFO included.
  Assumes the host model sep_host and a 40 MHz reference clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int         WC    = 300;
  localparam int         TPD   = 4000;
  localparam logic [7:0] SIG_V = 8'hC3; // Arbitrary signature value
  logic       ref_clk, rst_n, cs_n, sck, si, hold_n, so_out, so_oe, busy, deep_sleep;
  logic       rx_stb, leak;
  logic [7:0] rx_byte, d0, d1;
  logic [7:0] expq[$];
  logic [7:0] txq[$];
  logic [31:0] seed = 32'd38;
  int         miscompares = 0;
  int         tests_run = 0;
  int         cyc = 0;
  sep_port #(.SIG(SIG_V), .WC_CYC(WC)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe),
    .busy(busy), .deep_sleep(deep_sleep));
  sep_host host_u (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .so_out(so_out), .so_oe(so_oe), .rx_byte(rx_byte), .rx_stb(rx_stb), .leak(leak));
  // Xorshift source
  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd8
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  // Wait, bounded, for busy (0) or deep_sleep (1) to reach a level
  task automatic wait_sig(input bit which, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((which ? deep_sleep : busy) !== lvl && n < lim)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(which ? "deep_sleep" : "busy", {7'h0, lvl}, {7'h0, which ? deep_sleep : busy});
  endtask : wait_sig
  task automatic status(input logic [7:0] exp);
    expq.push_back(exp);
    host_u.frame({8'h05}, 1, -1, 0);
  endtask : status
  task automatic endt(input string nm);
    $display("test %s done, %0d checks so far", nm, tests_run);
  endtask : endt
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Compare each collected byte with the oldest note; cut a hang short
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (rx_stb === 1'b1)
      chk("rx_byte", expq.size() > 0 ? expq.pop_front() : 8'h00, rx_byte);
    if (cyc == 40000)
    begin
      miscompares++;
      close_out();
    end
  end
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    status(8'h00);
    host_u.frame({8'h06}, 0, -1, 0);
    status(8'h02);
    host_u.frame({8'h04}, 0, -1, 0);
    status(8'h00);
    host_u.frame({8'h06}, 0, -1, 1);
    status(8'h00);
    host_u.frame({8'hD8, 8'h00, 8'h00}, 0, -1, 0);
    host_u.frame({8'hC7}, 0, -1, 0);
    chk("busy", 8'h00, {7'h0, busy});
    endt("latch");
    d0 = rnd8();
    d1 = rnd8();
    host_u.frame({8'h06}, 0, -1, 0);
    host_u.frame({8'h02, 8'hFF, 8'hFF, d0}, 0, -1, 0);
    chk("busy", 8'h01, {7'h0, busy});
    wait_sig(0, 1'b0, WC + 20);
    host_u.frame({8'h06}, 0, -1, 0);
    host_u.frame({8'h02, 8'h00, 8'h00, d1}, 0, -1, 0);
    wait_sig(0, 1'b0, WC + 20);
    expq.push_back(d0);
    expq.push_back(d1);
    host_u.frame({8'h03, 8'hFF, 8'hFF}, 2, 1, 0);
    chk("leak", 8'h00, {7'h0, leak});
    endt("write_read");
    host_u.frame({8'h06}, 0, -1, 0);
    host_u.frame({8'h02, 8'h00, 8'h00, rnd8()}, 0, -1, 3);
    chk("busy", 8'h00, {7'h0, busy});
    status(8'h02);
    host_u.frame({8'h42, 8'h00, 8'h00}, 0, -1, 0);
    chk("busy", 8'h01, {7'h0, busy});
    wait_sig(0, 1'b0, WC + 20);
    expq.push_back(8'hFF);
    host_u.frame({8'h03, 8'h00, 8'h00}, 1, -1, 0);
    endt("erase");
    host_u.frame({8'hB9}, 0, -1, 0);
    wait_sig(1, 1'b1, TPD - 8);
    host_u.frame({8'h06}, 0, -1, 0);
    expq.push_back(SIG_V);
    host_u.frame({8'hAB, 8'h00, 8'h00}, 1, -1, 0);
    chk("deep_sleep", 8'h00, {7'h0, deep_sleep});
    status(8'h00);
    endt("sleep");
    // Six-byte page write, then a paused read past the prefetch depth and a fresh read
    txq = {8'h02, 8'h12, 8'h30};
    repeat (6)
    begin
      d0 = rnd8();
      txq.push_back(d0);
      expq.push_back(d0);
    end
    d1 = txq[5];
    host_u.frame({8'h06}, 0, -1, 0);
    host_u.frame(txq, 0, -1, 0);
    chk("busy", 8'h01, {7'h0, busy});
    wait_sig(0, 1'b0, WC + 20);
    host_u.frame({8'h03, 8'h12, 8'h30}, 6, 4, 0);
    expq.push_back(d1);
    host_u.frame({8'h03, 8'h12, 8'h32}, 1, -1, 0);
    chk("leak", 8'h00, {7'h0, leak});
    endt("prefetch");
    host_u.frame({8'h06}, 0, -1, 0);
    host_u.frame({8'h01, 8'h8C}, 0, -1, 0);
    chk("busy", 8'h01, {7'h0, busy});
    wait_sig(0, 1'b0, WC + 20);
    status(8'h8C);
    endt("status_write");
    close_out();
  end
endmodule : tb
`default_nettype wire
